// File: design/upms_pin_mux.sv
// upms_pin_mux: pin function select for upper address, port 7, analog
// port and the two external interrupt pins, with an APB register file.
// assumes: pclk 25 MHz, presetn async low; pin inputs synchronous.
`timescale 1ns/1ps
// Functional notes
// - upper pins are port in single-chip mode or when upper control picks port
// - upper pins drive address bits 21..23 when bus enabled and control picks address
// - pwm channel five reaches its pin only when its output enable is set
// - pulse generator trigger taken from pin only when trigger enable set
// - pulse generator output reaches pin only when its output enable set
// - adc trigger taken from pin only while its trigger enable set
// - eeprom data in and out use their pins only while eeprom enable set
// - eeprom clock and chip select drive pins only while eeprom enable set
// - each dac output owns its pin only while its enable is set
// - analog pins act as port when analog enable bit picks port
// - analog pins feed adc when enable bit picks analog; last feeds comparator
// - interrupt pins always keep port function
module upms_pin_mux (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core side functions
    input  wire logic [23:21] ext_addr_bits,
    input  wire logic        pwm_channel_five_out,
    input  wire logic        pulse_gen_out,
    input  wire logic        eeprom_serial_data_out,
    input  wire logic        eeprom_serial_clock_out,
    input  wire logic        eeprom_chip_select_out,
    output logic             pulse_gen_trigger_in,
    output logic             adc_trigger_in,
    output logic             eeprom_serial_data_in,
    output logic             ext_irq_in_zero,
    output logic             ext_irq_in_one,
    // analog switch controls
    output logic [7:0]       adc_analog_inputs,
    output logic             level_comparator_in,
    output logic             dac_out_zero,
    output logic             dac_out_one,
    // digital pins: upper 5..7, port7 0..6, port8 0..1, then analog 0..7
    input  wire logic [12:0] pin_in,
    output logic      [12:0] pin_out,
    output logic      [12:0] pin_oe_n,
    input  wire logic [7:0]  analog_port_bits_in,
    output logic      [7:0]  analog_port_bits_out,
    output logic      [7:0]  analog_port_bits_oe_n
);

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [1:0]  mode_q;
    logic [6:0]  periph_q;
    logic [7:0]  analog_q;
    logic [20:0] port_do_q;
    logic [20:0] port_dr_q;
    logic [12:0] pin_in_q;
    logic [7:0]  ana_in_q;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;

    function automatic logic decode_ok(input logic [7:0] a);
        decode_ok = (a == upms_pkg::OFF_MODE)    || (a == upms_pkg::OFF_PERIPH)
                 || (a == upms_pkg::OFF_ANALOG)  || (a == upms_pkg::OFF_PORT_DO)
                 || (a == upms_pkg::OFF_PORT_DR) || (a == upms_pkg::OFF_PIN_IN);
    endfunction

    assign addr_ok = decode_ok(paddr);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    // read data is loaded in the setup cycle and stands through the access phase
    assign rd_en   = psel && !penable && !pwrite;
    // zero wait states: every access ends in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= upms_pkg::RST_MODE;
            periph_q  <= upms_pkg::RST_PERIPH;
            analog_q  <= upms_pkg::RST_ANALOG;
            port_do_q <= 21'h000000;
            port_dr_q <= 21'h000000;
        end else if (wr_en) begin
            case (paddr)
                upms_pkg::OFF_MODE:    mode_q    <= pwdata[1:0];
                upms_pkg::OFF_PERIPH:  periph_q  <= pwdata[6:0];
                upms_pkg::OFF_ANALOG:  analog_q  <= pwdata[7:0];
                upms_pkg::OFF_PORT_DO: port_do_q <= pwdata[20:0];
                upms_pkg::OFF_PORT_DR: port_dr_q <= pwdata[20:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pin sampling and read data
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_in_q <= upms_pkg::RST_PORT;
            ana_in_q <= 8'h00;
        end else begin
            pin_in_q <= pin_in;
            // pins given to the adc read back as zero
            ana_in_q <= analog_port_bits_in & ~analog_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            case (paddr)
                upms_pkg::OFF_MODE:    prdata <= {30'h00000000, mode_q};
                upms_pkg::OFF_PERIPH:  prdata <= {25'h0000000, periph_q};
                upms_pkg::OFF_ANALOG:  prdata <= {24'h000000, analog_q};
                upms_pkg::OFF_PORT_DO: prdata <= {11'h000, port_do_q};
                upms_pkg::OFF_PORT_DR: prdata <= {11'h000, port_dr_q};
                upms_pkg::OFF_PIN_IN:  prdata <= {11'h000, ana_in_q, pin_in_q};
                default:               prdata <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // function selection
    // ----------------------------------------------------------------
    logic        addr_mode;
    logic [12:0] fn_en;
    logic [12:0] fn_out;
    logic [12:0] fn_drive;

    assign addr_mode = mode_q[upms_pkg::MODE_EXT_BUS_BIT] && mode_q[upms_pkg::MODE_UPPER_ADR_BIT];

    always_comb begin
        fn_en    = 13'h0000;
        fn_out   = 13'h0000;
        fn_drive = 13'h0000;
        // address mode owns all three upper pins, ahead of pwm and pulse output
        if (addr_mode) begin
            fn_en[2:0]    = 3'h7;
            fn_out[2:0]   = ext_addr_bits;
            fn_drive[2:0] = 3'h7;
        end else begin
            fn_en[upms_pkg::PIN_U5]    = periph_q[upms_pkg::PER_PWM_FIVE_OE_BIT];
            fn_out[upms_pkg::PIN_U5]   = pwm_channel_five_out;
            fn_drive[upms_pkg::PIN_U5] = 1'b1;
            fn_en[upms_pkg::PIN_U7]    = periph_q[upms_pkg::PER_PG_OE_BIT];
            fn_out[upms_pkg::PIN_U7]   = pulse_gen_out;
            fn_drive[upms_pkg::PIN_U7] = 1'b1;
        end
        fn_en[upms_pkg::PIN_PORT7_B2]    = periph_q[upms_pkg::PER_EEP_EN_BIT];
        fn_out[upms_pkg::PIN_PORT7_B2]   = eeprom_serial_data_out;
        fn_drive[upms_pkg::PIN_PORT7_B2] = 1'b1;
        fn_en[upms_pkg::PIN_PORT7_B3]    = periph_q[upms_pkg::PER_EEP_EN_BIT];
        fn_out[upms_pkg::PIN_PORT7_B3]   = eeprom_serial_clock_out;
        fn_drive[upms_pkg::PIN_PORT7_B3] = 1'b1;
        fn_en[upms_pkg::PIN_PORT7_B4]    = periph_q[upms_pkg::PER_EEP_EN_BIT];
        fn_out[upms_pkg::PIN_PORT7_B4]   = eeprom_chip_select_out;
        fn_drive[upms_pkg::PIN_PORT7_B4] = 1'b1;
        // dac pins: digital driver released, analog switch closed
        fn_en[upms_pkg::PIN_PORT7_B5]    = periph_q[upms_pkg::PER_DAC0_EN_BIT];
        fn_en[upms_pkg::PIN_PORT7_B6]    = periph_q[upms_pkg::PER_DAC1_EN_BIT];
        // interrupt pins never get a function override
        fn_en[upms_pkg::PIN_PORT8_B0]    = 1'b0;
        fn_en[upms_pkg::PIN_PORT8_B1]    = 1'b0;
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    // index 12 has no pin behind it; its register bits are spare
    genvar gi;
    generate
        for (gi = 0; gi < upms_pkg::NUM_PINS; gi++) begin : g_pin
            upms_sel_bit u_sel (
                .fn_en      (fn_en[gi]),
                .fn_out     (fn_out[gi]),
                .fn_drive   (fn_drive[gi]),
                .port_out   (port_do_q[gi]),
                .port_drive (port_dr_q[gi]),
                .pin_out    (pin_out[gi]),
                .pin_oe_n   (pin_oe_n[gi])
            );
        end
        for (gi = 0; gi < upms_pkg::NUM_ANALOG; gi++) begin : g_ana
            assign analog_port_bits_out[gi]  = port_do_q[upms_pkg::NUM_PINS + gi];
            assign analog_port_bits_oe_n[gi] = analog_q[gi] | ~port_dr_q[upms_pkg::NUM_PINS + gi];
            assign adc_analog_inputs[gi]     = analog_q[gi];
        end
    endgenerate

    assign level_comparator_in = analog_q[upms_pkg::NUM_ANALOG - 1];
    assign dac_out_zero        = periph_q[upms_pkg::PER_DAC0_EN_BIT];
    assign dac_out_one         = periph_q[upms_pkg::PER_DAC1_EN_BIT];

    // ----------------------------------------------------------------
    // inputs to peripherals
    // ----------------------------------------------------------------
    // the trigger pin stays a port pin; the trigger only taps its level
    assign pulse_gen_trigger_in  = periph_q[upms_pkg::PER_PG_TRIG_BIT] & pin_in[upms_pkg::PIN_U6];
    assign adc_trigger_in        = periph_q[upms_pkg::PER_ADC_TRIG_BIT] & pin_in[upms_pkg::PIN_PORT7_B0];
    assign eeprom_serial_data_in = periph_q[upms_pkg::PER_EEP_EN_BIT] & pin_in[upms_pkg::PIN_PORT7_B1];
    // software keeps other drivers off on these pins while interrupts are used
    assign ext_irq_in_zero       = pin_in[upms_pkg::PIN_PORT8_B0];
    assign ext_irq_in_one        = pin_in[upms_pkg::PIN_PORT8_B1];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_upper_port_mode: assert property (!addr_mode && !periph_q[0] && !periph_q[2] |-> pin_out[2:0] == port_do_q[2:0]
        && pin_oe_n[2:0] == ~port_dr_q[2:0])
        else $error("upper pin not in port mode");
    a_upper_addr_out: assert property (addr_mode |-> pin_out[2:0] == ext_addr_bits && pin_oe_n[2:0] == 3'h0)
        else $error("address bits not on upper pins");
    a_pwm_gate: assert property (!addr_mode && periph_q[0] |-> pin_out[0] == pwm_channel_five_out)
        else $error("pwm five not on its pin");
    a_trig_gate: assert property (!periph_q[1] |-> !pulse_gen_trigger_in)
        else $error("pulse trigger leaked");
    a_pg_out_gate: assert property (!addr_mode && periph_q[2] |-> pin_out[2] == pulse_gen_out && !pin_oe_n[2])
        else $error("pulse output not on its pin");
    a_adc_trig: assert property (!periph_q[3] |-> !adc_trigger_in)
        else $error("adc trigger leaked");
    a_eep_pins: assert property (periph_q[4] |-> pin_out[7:5] ==
        {eeprom_chip_select_out, eeprom_serial_clock_out, eeprom_serial_data_out})
        else $error("eeprom pins not driven");
    a_eep_din: assert property (!periph_q[4] |-> !eeprom_serial_data_in)
        else $error("eeprom data in leaked");
    a_dac_sw: assert property (periph_q[5] |-> dac_out_zero && pin_oe_n[8])
        else $error("dac zero not switched");
    a_analog_port: assert property ((adc_analog_inputs & ~analog_q) == 8'h00
        && (analog_port_bits_oe_n | analog_q) == (~port_dr_q[20:13] | analog_q))
        else $error("analog switch on in port mode");
    a_analog_in: assert property (analog_q[7] |-> level_comparator_in && analog_port_bits_oe_n[7])
        else $error("analog seven not released");
    a_irq_port: assert property (pin_out[11:10] == port_do_q[11:10] && pin_oe_n[11:10] == ~port_dr_q[11:10])
        else $error("interrupt pin overridden");
    a_addr_prio: assert property (addr_mode && periph_q[0] |-> pin_out[0] == ext_addr_bits[21])
        else $error("pwm beat address");

    // ----------------------------------------------------------------
    // assertions: input gates, released pins and bus
    // ----------------------------------------------------------------
    a_trig_pass: assert property (periph_q[1] |-> pulse_gen_trigger_in == pin_in[1])
        else $error("pulse trigger not taken from pin");
    a_adc_pass: assert property (periph_q[3] |-> adc_trigger_in == pin_in[3])
        else $error("adc trigger not taken from pin");
    a_eep_din_pass: assert property (periph_q[4] |-> eeprom_serial_data_in == pin_in[4])
        else $error("eeprom data in not taken from pin");
    a_eep_oe: assert property (periph_q[4] |-> pin_oe_n[7:5] == 3'h0)
        else $error("eeprom pins not enabled");
    a_eep_off: assert property (!periph_q[4] |-> pin_out[7:6] == port_do_q[7:6])
        else $error("eeprom outputs on port pins");
    a_eep_dout_off: assert property (!periph_q[4] |-> pin_out[5] == port_do_q[5])
        else $error("eeprom data out on port pin");
    a_pwm_off: assert property (!addr_mode && !periph_q[0] |-> pin_out[0] == port_do_q[0])
        else $error("pwm five on port pin");
    a_pg_off: assert property (!addr_mode && !periph_q[2] |-> pin_out[2] == port_do_q[2])
        else $error("pulse output on port pin");
    a_dac1_sw: assert property (periph_q[6] |-> dac_out_one && pin_oe_n[9])
        else $error("dac one not switched");
    a_dac_off: assert property (!periph_q[5] |-> !dac_out_zero && pin_oe_n[8] == !port_dr_q[8])
        else $error("dac zero switched while off");
    a_analog_sw: assert property (adc_analog_inputs == analog_q)
        else $error("analog switch not following enable");
    a_analog_rel: assert property ((analog_port_bits_oe_n & analog_q) == analog_q)
        else $error("analog pin still driven");
    a_ana_port_out: assert property ((analog_port_bits_out & ~analog_q) == (port_do_q[20:13] & ~analog_q))
        else $error("analog port data wrong");
    a_comp_tap: assert property (level_comparator_in == adc_analog_inputs[7])
        else $error("comparator not on last analog pin");
    a_irq_pass: assert property (ext_irq_in_zero == pin_in[10] && ext_irq_in_one == pin_in[11])
        else $error("interrupt input not from pin");
    a_wr_ignored: assert property (psel && penable && pwrite && !addr_ok |=> $stable(mode_q) && $stable(periph_q))
        else $error("unmapped write changed a register");
    a_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed outside a read");
    a_err_ok: assert property (psel && penable && addr_ok |-> !pslverr)
        else $error("error on a mapped address");
    a_err_map: assert property (psel && penable && !addr_ok |-> pslverr)
        else $error("no error on an unmapped address");

    c_addr_mode: cover property (addr_mode);
    c_pwm_on: cover property (!addr_mode && periph_q[0]);
    c_eeprom_on: cover property (periph_q[4] && !addr_mode);
    c_analog_all: cover property (analog_q == 8'hFF);
    c_dac_both: cover property (dac_out_zero && dac_out_one);

endmodule

// File: design/upms_pkg.sv
// upms_pkg: register map, field positions and reset values for the
// upper port pin function select block.
// assumes: a 32-bit APB slave; offsets are byte addresses.
package upms_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_MODE    = 8'h00;
    localparam logic [7:0] OFF_PERIPH  = 8'h04;
    localparam logic [7:0] OFF_ANALOG  = 8'h08;
    localparam logic [7:0] OFF_PORT_DO = 8'h0C;
    localparam logic [7:0] OFF_PORT_DR = 8'h10;
    localparam logic [7:0] OFF_PIN_IN  = 8'h14;

    // ----------------------------------------------------------------
    // mode register fields
    // ----------------------------------------------------------------
    localparam int MODE_EXT_BUS_BIT   = 0;
    localparam int MODE_UPPER_ADR_BIT = 1;

    // ----------------------------------------------------------------
    // peripheral enable register fields
    // ----------------------------------------------------------------
    localparam int PER_PWM_FIVE_OE_BIT = 0;
    localparam int PER_PG_TRIG_BIT  = 1;
    localparam int PER_PG_OE_BIT    = 2;
    localparam int PER_ADC_TRIG_BIT = 3;
    localparam int PER_EEP_EN_BIT   = 4;
    localparam int PER_DAC0_EN_BIT  = 5;
    localparam int PER_DAC1_EN_BIT  = 6;
    localparam int PER_WIDTH        = 7;

    // ----------------------------------------------------------------
    // pin indices in the port vectors
    // ----------------------------------------------------------------
    localparam int NUM_PINS     = 13;
    localparam int PIN_U5       = 0;
    localparam int PIN_U6       = 1;
    localparam int PIN_U7       = 2;
    localparam int PIN_PORT7_B0 = 3;
    localparam int PIN_PORT7_B1 = 4;
    localparam int PIN_PORT7_B2 = 5;
    localparam int PIN_PORT7_B3 = 6;
    localparam int PIN_PORT7_B4 = 7;
    localparam int PIN_PORT7_B5 = 8;
    localparam int PIN_PORT7_B6 = 9;
    localparam int PIN_PORT8_B0 = 10;
    localparam int PIN_PORT8_B1 = 11;
    localparam int NUM_ANALOG   = 8;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [1:0]  RST_MODE    = 2'h0;
    localparam logic [6:0]  RST_PERIPH  = 7'h00;
    localparam logic [7:0]  RST_ANALOG  = 8'h00;
    localparam logic [12:0] RST_PORT    = 13'h0000;

endpackage

// File: design/upms_sel_bit.sv
// upms_sel_bit: one pin's output selector between port and a function.
// assumes: all inputs synchronous to pclk.
`timescale 1ns/1ps
module upms_sel_bit (
    // function request
    input  wire logic fn_en,
    input  wire logic fn_out,
    input  wire logic fn_drive,
    // port fallback
    input  wire logic port_out,
    input  wire logic port_drive,
    // pin
    output logic      pin_out,
    output logic      pin_oe_n
);
    assign pin_out  = fn_en ? fn_out : port_out;
    assign pin_oe_n = fn_en ? ~fn_drive : ~port_drive;
endmodule

// File: sim/upms_far_model.sv
// upms_far_model: board wiring and on-chip peripherals around the pin mux.
// assumes: the bench sets board levels and peripheral values by non-blocking assignment.
`timescale 1ns/1ps
module upms_far_model (
    // bench controls
    input  wire logic [20:0]  board,
    input  wire logic [7:0]   fn,
    // digital pins
    input  wire logic [12:0]  pin_out,
    input  wire logic [12:0]  pin_oe_n,
    output logic      [12:0]  pin_in,
    // analog port pins
    input  wire logic [7:0]   an_out,
    input  wire logic [7:0]   an_oe_n,
    output logic      [7:0]   an_in,
    // peripheral outputs: pwm, pulse, eeprom data, clock, select
    output logic      [23:21] addr,
    output logic      [4:0]   per
);
    // ----------------------------------------------------------------
    // pin levels
    // ----------------------------------------------------------------
    // a released pin shows the level the board puts on it
    assign pin_in = (pin_out & ~pin_oe_n) | (board[12:0] & pin_oe_n);
    assign an_in  = (an_out & ~an_oe_n) | (board[20:13] & an_oe_n);
    assign addr   = fn[2:0];
    assign per    = fn[7:3];
endmodule

// File: sim/upper_port_pin_function_select_tb.sv
// upper_port_pin_function_select_tb: directed bench for the pin mux.
// assumes: zero-wait apb slave; far side modelled in upms_far_model.
`timescale 1ns/1ps
module upper_port_pin_function_select_tb;
    localparam logic [20:0] DOUT = 21'h015AD2;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
    logic [7:0]  paddr, fn, adc_in, an_in, an_out, an_oe_n;
    logic [31:0] pwdata, prdata, rd;
    logic [23:21] addr;
    logic [4:0]  per;
    logic        pg_trig, adc_trig, eep_di, irq0, irq1, cmp_in, dac0, dac1;
    logic [12:0] pin_in, pin_out, pin_oe_n;
    logic [20:0] board;
    int          bad_count, checks;

    upms_pin_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_addr_bits(addr), .pwm_channel_five_out(per[0]), .pulse_gen_out(per[1]),
        .eeprom_serial_data_out(per[2]), .eeprom_serial_clock_out(per[3]), .eeprom_chip_select_out(per[4]),
        .pulse_gen_trigger_in(pg_trig), .adc_trigger_in(adc_trig), .eeprom_serial_data_in(eep_di),
        .ext_irq_in_zero(irq0), .ext_irq_in_one(irq1), .adc_analog_inputs(adc_in),
        .level_comparator_in(cmp_in), .dac_out_zero(dac0), .dac_out_one(dac1), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .analog_port_bits_in(an_in),
        .analog_port_bits_out(an_out), .analog_port_bits_oe_n(an_oe_n));
    upms_far_model u_far (.board(board), .fn(fn), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in),
        .an_out(an_out), .an_oe_n(an_oe_n), .an_in(an_in), .addr(addr), .per(per));

    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; returns at the following falling edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        ok = (pready === 1'b1);
        rd = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
        if (!ok) begin
            bad_count++;
            results();
        end
    endtask
    task automatic drv(input logic [20:0] b, input logic [7:0] f);
        @(posedge pclk);
        board <= b;
        fn <= f;
        @(negedge pclk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        logic [7:0] offs [6];
        offs = '{upms_pkg::OFF_MODE, upms_pkg::OFF_PERIPH, upms_pkg::OFF_ANALOG,
                 upms_pkg::OFF_PORT_DO, upms_pkg::OFF_PORT_DR, upms_pkg::OFF_PIN_IN};
        chk(32'({an_oe_n, pin_oe_n}), 32'h1FFFFF);
        foreach (offs[i]) begin
            apb(1'b0, offs[i], 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, 8'h40, 32'h0);
        chk({rd[30:0], serr}, 32'h1);
        apb(1'b1, upms_pkg::OFF_MODE, 32'hFFFFFFFF);
        apb(1'b0, upms_pkg::OFF_MODE, 32'h0);
        chk(rd, 32'h3);
    endtask
    task automatic t_upper();
        logic [2:0] e;
        apb(1'b1, upms_pkg::OFF_PORT_DO, 32'(DOUT));
        apb(1'b1, upms_pkg::OFF_PORT_DR, 32'h1FE3FF);
        for (int k = 0; k < 16; k++) begin
            drv(21'h0, k[3] ? 8'h3A : 8'h3D);
            apb(1'b1, upms_pkg::OFF_MODE, 32'(k[1:0]));
            apb(1'b1, upms_pkg::OFF_PERIPH, k[2] ? 32'h5 : 32'h0);
            e = DOUT[2:0];
            if (k[2]) begin
                e = {fn[4], e[1], fn[3]};
            end
            if (k[1:0] == 2'b11) begin
                e = fn[2:0];
            end
            chk(32'({pin_oe_n[2:0], pin_out[2:0]}), 32'(e));
        end
    endtask
    task automatic t_trig();
        apb(1'b1, upms_pkg::OFF_MODE, 32'h0);
        apb(1'b1, upms_pkg::OFF_PORT_DR, 32'h1FE3E5);
        for (int k = 0; k < 4; k++) begin
            drv(k[0] ? 21'h1FFFFF : 21'h0, 8'h3D);
            apb(1'b1, upms_pkg::OFF_PERIPH, k[1] ? 32'h1A : 32'h0);
            chk(32'({pg_trig, adc_trig, eep_di}), k[1] ? 32'({3{k[0]}}) : 32'h0);
            chk(32'({pin_oe_n[7:5], pin_out[7:5]}), k[1] ? 32'(fn[7:5]) : 32'(DOUT[7:5]));
        end
    endtask
    task automatic t_dacirq();
        for (int k = 0; k < 4; k++) begin
            drv(k[0] ? 21'h1FFFFF : 21'h0, 8'h3D);
            apb(1'b1, upms_pkg::OFF_PERIPH, k[1] ? 32'h7F : 32'h0);
            chk(32'({dac1, dac0, pin_oe_n[9:8]}), k[1] ? 32'hF : 32'h0);
            chk(32'({irq1, irq0, pin_oe_n[11:10]}), 32'({k[0], k[0], 2'b11}));
        end
    endtask
    task automatic t_analog();
        logic [7:0] a;
        for (int k = 0; k < 2; k++) begin
            a = k[0] ? 8'h7F : 8'h80;
            apb(1'b1, upms_pkg::OFF_ANALOG, 32'(a));
            chk(32'({adc_in, cmp_in}), 32'({a, a[7]}));
            chk(32'({an_oe_n, an_out & ~a}), 32'({a, DOUT[20:13] & ~a}));
        end
    endtask
    task automatic t_readback();
        apb(1'b1, upms_pkg::OFF_PORT_DR, 32'h0);
        apb(1'b1, upms_pkg::OFF_PERIPH, 32'h0);
        drv(21'h1FFFFF, 8'h3D);
        apb(1'b0, upms_pkg::OFF_PIN_IN, 32'h0);
        chk(rd, 32'h00101FFF);
        apb(1'b1, upms_pkg::OFF_PIN_IN, 32'h0);
        apb(1'b0, upms_pkg::OFF_PORT_DO, 32'h0);
        chk(rd, 32'(DOUT));
        apb(1'b0, upms_pkg::OFF_ANALOG, 32'h0);
        chk(rd, 32'h7F);
        apb(1'b1, 8'h40, 32'h1);
        chk(32'(serr), 32'h1);
        apb(1'b0, upms_pkg::OFF_MODE, 32'h0);
        chk(rd, 32'h0);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        board = 21'h0;
        fn = 8'h00;
        bad_count = 0;
        checks = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_regs();
        t_upper();
        t_trig();
        t_dacirq();
        t_analog();
        t_readback();
        results();
    end
endmodule
